// *** pkg/codec_defines.svh ***
// register offsets, field positions, reset values of the parallel word codec
// assumes inclusion by bare name from the top module, the port checker and the bench
`ifndef CODEC_DEFINES_SVH
`define CODEC_DEFINES_SVH

// ==========================================
// geometry
`define NUM_CH 4
`define WORD_W 10
`define STAT_W 12

// ==========================================
// register offsets (byte addresses)
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define MASK_OFFSET 12'h008
`define DISP_OFFSET 12'h00c
`define ERRCNT_OFFSET 12'h010

// ==========================================
// field positions
`define CTRL_MODE_BIT 0
`define STAT_RXERR_LSB 0
`define STAT_TXWORD_LSB 4
`define STAT_RXK_LSB 8
`define DISP_TX_LSB 0
`define DISP_RX_LSB 4

// ==========================================
// reset values and error counter saturation value
`define MODE_RESET 1'b0
`define MASK_RESET 12'h000
`define STATUS_RESET 12'h000
`define RD_RESET 1'b0
`define ERRCNT_MAX 8'hff

`endif

// *** pkg/codec_pkg.sv ***
// types and 8b/10b sub-block coding shared by encoder and decoder
// assumes sub-blocks held with bit a (or f) as the most significant bit
package codec_pkg;

  typedef logic [9:0] code_group_t;

  typedef struct packed {
    logic err;
    logic k;
    logic [7:0] data;
    logic rd;
  } decode_result_t;

  // ==========================================
  // 5b/6b, abcdei, running disparity negative column
  function automatic logic [5:0] enc6(input logic [4:0] x, input logic k, input logic rd);
    logic [5:0] c;
    c = 6'h00;
    case (x)
      5'd0: c = 6'b100111;
      5'd1: c = 6'b011101;
      5'd2: c = 6'b101101;
      5'd3: c = 6'b110001;
      5'd4: c = 6'b110101;
      5'd5: c = 6'b101001;
      5'd6: c = 6'b011001;
      5'd7: c = 6'b111000;
      5'd8: c = 6'b111001;
      5'd9: c = 6'b100101;
      5'd10: c = 6'b010101;
      5'd11: c = 6'b110100;
      5'd12: c = 6'b001101;
      5'd13: c = 6'b101100;
      5'd14: c = 6'b011100;
      5'd15: c = 6'b010111;
      5'd16: c = 6'b011011;
      5'd17: c = 6'b100011;
      5'd18: c = 6'b010011;
      5'd19: c = 6'b110010;
      5'd20: c = 6'b001011;
      5'd21: c = 6'b101010;
      5'd22: c = 6'b011010;
      5'd23: c = 6'b111010;
      5'd24: c = 6'b110011;
      5'd25: c = 6'b100110;
      5'd26: c = 6'b010110;
      5'd27: c = 6'b110110;
      5'd28: c = 6'b001110;
      5'd29: c = 6'b101110;
      5'd30: c = 6'b011110;
      default: c = 6'b101011;
    endcase
    if (k && x == 5'd28) begin
      c = 6'b001111;
    end
    // unbalanced groups and the d.7 pair flip under positive disparity
    if (rd && ($countones(c) != 3 || x == 5'd7)) begin
      c = ~c;
    end
    return c;
  endfunction

  // ==========================================
  // 3b/4b, fghj; alt selects the alternate .7 form
  function automatic logic [3:0] enc4(input logic [2:0] y, input logic alt, input logic k28,
                                      input logic rd);
    logic [3:0] c;
    c = 4'h0;
    case (y)
      3'd0: c = 4'b1011;
      3'd1: c = 4'b1001;
      3'd2: c = 4'b0101;
      3'd3: c = 4'b1100;
      3'd4: c = 4'b1101;
      3'd5: c = 4'b1010;
      3'd6: c = 4'b0110;
      default: c = alt ? 4'b0111 : 4'b1110;
    endcase
    if (rd && ($countones(c) != 2 || y == 3'd3)) begin
      c = ~c;
    end
    // k28 balanced groups other than .3 take the inverted form after a negative six-bit group
    if (k28 && !rd && $countones(c) == 2 && y != 3'd3) begin
      c = ~c;
    end
    return c;
  endfunction

  function automatic logic alt7_needed(input logic [4:0] x, input logic k, input logic rd);
    return k || (!rd && (x == 5'd17 || x == 5'd18 || x == 5'd20))
           || (rd && (x == 5'd11 || x == 5'd13 || x == 5'd14));
  endfunction

  function automatic logic rd_after6(input logic [5:0] c, input logic rd);
    logic r;
    r = rd;
    if ($countones(c) > 3 || c == 6'b000111) begin
      r = 1'b1;
    end else if ($countones(c) < 3 || c == 6'b111000) begin
      r = 1'b0;
    end
    return r;
  endfunction

  function automatic logic rd_after4(input logic [3:0] c, input logic rd);
    logic r;
    r = rd;
    if ($countones(c) > 2 || c == 4'b0011) begin
      r = 1'b1;
    end else if ($countones(c) < 2 || c == 4'b1100) begin
      r = 1'b0;
    end
    return r;
  endfunction

endpackage

// *** core/lane_8b10b_encoder.sv ***
// combinational 8b/10b encoder for one lane
// assumes the caller registers the code group and the running disparity
`timescale 1ns/1ps
module lane_8b10b_encoder (
  input wire logic [7:0] byte_in,
  input wire logic k_sel,
  input wire logic rd_in,
  output logic [9:0] code,
  output logic rd_out
);

  logic [5:0] six;
  logic [3:0] four;
  logic rd_mid;

  always_comb begin
    six = codec_pkg::enc6(byte_in[4:0], k_sel, rd_in);
    rd_mid = codec_pkg::rd_after6(six, rd_in);
    four = codec_pkg::enc4(byte_in[7:5], codec_pkg::alt7_needed(byte_in[4:0], k_sel, rd_mid),
                           k_sel && byte_in[4:0] == 5'd28, rd_mid);
    rd_out = codec_pkg::rd_after4(four, rd_mid);
    // bit 0 carries a, the first bit on the line; bit 9 carries j
    code = {four[0], four[1], four[2], four[3], six[0], six[1], six[2], six[3], six[4], six[5]};
  end

endmodule

// *** core/serdes_parallel_word_codec.sv ***
// four-lane parallel word interface with optional 8b/10b codec and apb registers
// assumes the serializer takes tx_code_group on tx_code_strobe and the
// deserializer offers aligned code groups on pclk with rx_code_strobe
//
// Function
// - ten-bit mode sends transmit word unchanged
// - transmit bit 9 is code group msb
// - eight-bit mode encodes bits 0-7, bit 7 msb
// - transmit bit 8 selects data or control code
// - each lane has its own transmit clock
// - ten-bit mode presents raw received group
// - eight-bit mode presents decoded byte, bit 7 msb
// - receive bit 9 flags decoding errors
// - receive bit 8 marks control symbols
// - coding follows the standard 8b/10b tables
`timescale 1ns/1ps
`include "codec_defines.svh"
module serdes_parallel_word_codec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output wire logic [31:0] prdata,
  output wire logic pready,
  output wire logic pslverr,
  input wire logic [3:0] tx_lane_clock,
  input wire logic [3:0][9:0] tx_parallel_lane_bits,
  output wire logic [3:0][9:0] tx_code_group,
  output wire logic [3:0] tx_code_strobe,
  input wire logic [3:0][9:0] rx_code_group,
  input wire logic [3:0] rx_code_strobe,
  output wire logic [3:0][9:0] rx_parallel_lane_bits,
  output wire logic [3:0] rx_word_strobe,
  output wire logic irq
);

  // ==========================================
  // decoding
  function automatic codec_pkg::decode_result_t decode_word(input codec_pkg::code_group_t c,
                                                           input logic rd);
    codec_pkg::decode_result_t r;
    logic [5:0] six;
    logic [3:0] four;
    logic [4:0] x;
    logic [2:0] y;
    logic found6;
    logic found4;
    logic k28;
    logic alt;
    logic mid;
    logic bad_disp;
    six = {c[0], c[1], c[2], c[3], c[4], c[5]};
    four = {c[6], c[7], c[8], c[9]};
    x = 5'd0;
    y = 3'd0;
    found6 = 1'b0;
    found4 = 1'b0;
    for (int i = 0; i < 32; i++) begin
      if (codec_pkg::enc6(5'(i), 1'b0, 1'b0) == six || codec_pkg::enc6(5'(i), 1'b0, 1'b1) == six) begin
        found6 = 1'b1;
        x = 5'(i);
      end
    end
    k28 = (six == 6'b001111) || (six == 6'b110000);
    if (k28) begin
      found6 = 1'b1;
      x = 5'd28;
    end
    // 111000 is legal only from negative disparity, 000111 only from positive
    bad_disp = (rd && ($countones(six) > 3 || six == 6'b111000))
               || (!rd && ($countones(six) < 3 || six == 6'b000111));
    mid = codec_pkg::rd_after6(six, rd);
    // k28 fghj forms repeat across y under opposite disparity, so the form
    // legal for the current disparity is tried first
    for (int j = 0; j < 8; j++) begin
      if (!found4 && codec_pkg::enc4(3'(j), 1'b0, k28, mid) == four) begin
        found4 = 1'b1;
        y = 3'(j);
      end
    end
    for (int j = 0; j < 8; j++) begin
      if (!found4 && codec_pkg::enc4(3'(j), 1'b0, k28, !mid) == four) begin
        found4 = 1'b1;
        y = 3'(j);
      end
    end
    alt = (four == 4'b0111) || (four == 4'b1000);
    if (alt) begin
      found4 = 1'b1;
      y = 3'd7;
    end
    bad_disp = bad_disp || (mid && ($countones(four) > 2 || four == 4'b1100))
               || (!mid && ($countones(four) < 2 || four == 4'b0011));
    r.data = {y, x};
    r.k = k28 || (alt && (x == 5'd23 || x == 5'd27 || x == 5'd29 || x == 5'd30));
    r.err = !found6 || !found4 || bad_disp;
    r.rd = codec_pkg::rd_after4(four, mid);
    return r;
  endfunction

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // ==========================================
  // registers and shared state
  logic mode_ff;
  logic [`STAT_W-1:0] status_ff;
  logic [`STAT_W-1:0] mask_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic irq_ff;
  logic [3:0][7:0] errcnt_ff;
  logic [`STAT_W-1:0] nxt_status;
  logic [31:0] nxt_rdata;
  logic nxt_err;
  wire logic [3:0] tx_cap_ev;
  wire logic [3:0] rx_err_ev;
  wire logic [3:0] rx_k_ev;
  wire logic [3:0] tx_rd_w;
  wire logic [3:0] rx_rd_w;
  logic setup;
  logic done;
  logic wr_done;
  logic rd_done;

  assign setup = psel && !penable;
  assign done = psel && penable && pready_ff;
  assign wr_done = done && pwrite;
  assign rd_done = done && !pwrite;

  // ==========================================
  // lanes
  for (genvar ch = 0; ch < `NUM_CH; ch++) begin : g_lane
    logic [2:0] tclk_sync_ff;
    logic [9:0] tdat_s1_ff;
    logic [9:0] tdat_s2_ff;
    logic [9:0] tword_ff;
    logic tcap_ff;
    logic [9:0] tcode_ff;
    logic tstrobe_ff;
    logic trd_ff;
    logic [9:0] enc_code;
    logic enc_rd;
    logic tedge;
    logic [9:0] rword_ff;
    logic rstrobe_ff;
    logic rrd_ff;
    codec_pkg::decode_result_t dec;

    // stage 0 feeds stage 1 only; edges are found between stages 1 and 2
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tclk_sync_ff <= 3'h0;
      end else begin
        tclk_sync_ff <= {tclk_sync_ff[1:0], tx_lane_clock[ch]};
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tdat_s1_ff <= 10'h000;
        tdat_s2_ff <= 10'h000;
      end else begin
        tdat_s1_ff <= tx_parallel_lane_bits[ch];
        tdat_s2_ff <= tdat_s1_ff;
      end
    end

    assign tedge = tclk_sync_ff[1] && !tclk_sync_ff[2];

    // data ride the same two stages as the clock, so they line up at the edge
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tword_ff <= 10'h000;
        tcap_ff <= 1'b0;
      end else begin
        tcap_ff <= tedge;
        if (tedge) begin
          tword_ff <= tdat_s2_ff;
        end
      end
    end

    lane_8b10b_encoder u_enc (
      .byte_in(tword_ff[7:0]),
      .k_sel(tword_ff[8]),
      .rd_in(trd_ff),
      .code(enc_code),
      .rd_out(enc_rd)
    );

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tcode_ff <= 10'h000;
        tstrobe_ff <= 1'b0;
        trd_ff <= `RD_RESET;
      end else begin
        tstrobe_ff <= tcap_ff;
        if (tcap_ff) begin
          if (mode_ff) begin
            tcode_ff <= enc_code;
            trd_ff <= enc_rd;
          end else begin
            tcode_ff <= tword_ff;
          end
        end
      end
    end

    assign dec = decode_word(rx_code_group[ch], rrd_ff);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        rword_ff <= 10'h000;
        rstrobe_ff <= 1'b0;
        rrd_ff <= `RD_RESET;
      end else begin
        rstrobe_ff <= rx_code_strobe[ch];
        if (rx_code_strobe[ch]) begin
          if (mode_ff) begin
            rword_ff <= {dec.err, dec.k, dec.data};
            rrd_ff <= dec.rd;
          end else begin
            rword_ff <= rx_code_group[ch];
          end
        end
      end
    end

    assign tx_code_group[ch] = tcode_ff;
    assign tx_code_strobe[ch] = tstrobe_ff;
    assign rx_parallel_lane_bits[ch] = rword_ff;
    assign rx_word_strobe[ch] = rstrobe_ff;
    assign tx_cap_ev[ch] = tcap_ff;
    assign rx_err_ev[ch] = rx_code_strobe[ch] && mode_ff && dec.err;
    assign rx_k_ev[ch] = rx_code_strobe[ch] && mode_ff && dec.k;
    assign tx_rd_w[ch] = trd_ff;
    assign rx_rd_w[ch] = rrd_ff;
  end

  // ==========================================
  // apb read mux and decode
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_err = 1'b0;
    if (addr_is(paddr, `CTRL_OFFSET)) begin
      nxt_rdata[`CTRL_MODE_BIT] = mode_ff;
    end else if (addr_is(paddr, `STATUS_OFFSET)) begin
      nxt_rdata[`STAT_W-1:0] = status_ff;
    end else if (addr_is(paddr, `MASK_OFFSET)) begin
      nxt_rdata[`STAT_W-1:0] = mask_ff;
    end else if (addr_is(paddr, `DISP_OFFSET)) begin
      nxt_rdata[`DISP_TX_LSB+:4] = tx_rd_w;
      nxt_rdata[`DISP_RX_LSB+:4] = rx_rd_w;
    end else if (addr_is(paddr, `ERRCNT_OFFSET)) begin
      nxt_rdata = errcnt_ff;
    end else begin
      nxt_err = 1'b1;
    end
  end

  // zero wait states: ready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      if (setup) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
        pslverr_ff <= nxt_err;
      end else if (done) begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= `MODE_RESET;
      mask_ff <= `MASK_RESET;
    end else if (wr_done) begin
      if (addr_is(paddr, `CTRL_OFFSET)) begin
        mode_ff <= pwdata[`CTRL_MODE_BIT];
      end
      if (addr_is(paddr, `MASK_OFFSET)) begin
        mask_ff <= pwdata[`STAT_W-1:0];
      end
    end
  end

  // ==========================================
  // sticky status, read clears, set wins
  // only the bits shown to software are cleared, so an event landing between
  // the setup capture and the access edge survives the read
  always_comb begin
    nxt_status = status_ff;
    if (rd_done && addr_is(paddr, `STATUS_OFFSET)) begin
      nxt_status = status_ff & ~prdata_ff[`STAT_W-1:0];
    end
    nxt_status[`STAT_RXERR_LSB+:4] = nxt_status[`STAT_RXERR_LSB+:4] | rx_err_ev;
    nxt_status[`STAT_TXWORD_LSB+:4] = nxt_status[`STAT_TXWORD_LSB+:4] | tx_cap_ev;
    nxt_status[`STAT_RXK_LSB+:4] = nxt_status[`STAT_RXK_LSB+:4] | rx_k_ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_ff <= `STATUS_RESET;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // error counters saturate; any write to the counter word clears them all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      errcnt_ff <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < `NUM_CH; i++) begin
        if (wr_done && addr_is(paddr, `ERRCNT_OFFSET)) begin
          errcnt_ff[i] <= 8'h00;
        end else if (rx_err_ev[i] && errcnt_ff[i] != `ERRCNT_MAX) begin
          errcnt_ff[i] <= errcnt_ff[i] + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_status & mask_ff);
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;

endmodule

// *** bench/codec_port_props.sv ***
// port checker for the four-lane parallel word codec
// assumes binding to the codec top; mode and mask are shadowed from apb writes
`timescale 1ns/1ps
`include "codec_defines.svh"
module codec_port_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] tx_lane_clock,
  input wire logic [3:0][9:0] tx_parallel_lane_bits,
  input wire logic [3:0][9:0] tx_code_group,
  input wire logic [3:0] tx_code_strobe,
  input wire logic [3:0][9:0] rx_code_group,
  input wire logic [3:0] rx_code_strobe,
  input wire logic [3:0][9:0] rx_parallel_lane_bits,
  input wire logic [3:0] rx_word_strobe,
  input wire logic irq
);
  logic wr_ok;
  logic mode_ff;
  logic [11:0] mask_ff;
  logic [3:0] clk_prev_ff;
  logic [3:0][9:0] cap_ff;
  assign wr_ok = psel && penable && pready && pwrite && !pslverr;
  // ==========================================
  // shadow registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= 1'b0;
      mask_ff <= 12'h000;
    end else if (wr_ok && paddr == `CTRL_OFFSET) begin
      mode_ff <= pwdata[0];
    end else if (wr_ok && paddr == `MASK_OFFSET) begin
      mask_ff <= pwdata[11:0];
    end
  end
  // host holds data around the rise, so the raw sample is the word taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev_ff <= 4'h0;
      cap_ff <= 40'h0;
    end else begin
      clk_prev_ff <= tx_lane_clock;
      for (int l = 0; l < 4; l++) begin
        if (tx_lane_clock[l] && !clk_prev_ff[l]) begin
          cap_ff[l] <= tx_parallel_lane_bits[l];
        end
      end
    end
  end
  // ==========================================
  // assertions
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  for (genvar g = 0; g < 4; g++) begin : g_lane
    chk_tx_raw_word: assert property (tx_code_strobe[g] && !mode_ff |-> tx_code_group[g] == cap_ff[g])
      else $error("raw transmit word altered");
    chk_tx_k_group: assert property (tx_code_strobe[g] && mode_ff && cap_ff[g] == 10'h1bc |->
      tx_code_group[g] inside {10'h17c, 10'h283}) else $error("control byte badly encoded");
    chk_tx_d_group: assert property (tx_code_strobe[g] && mode_ff && cap_ff[g] == 10'h0b5 |->
      tx_code_group[g] == 10'h155) else $error("data byte badly encoded");
    chk_tx_lane_timing: assert property (tx_lane_clock[g] && !clk_prev_ff[g] |-> ##[2:7] tx_code_strobe[g])
      else $error("lane word not taken");
    chk_rx_raw_word: assert property (rx_code_strobe[g] && !mode_ff |=> rx_word_strobe[g] &&
      rx_parallel_lane_bits[g] == $past(rx_code_group[g])) else $error("raw receive word altered");
    chk_rx_k_symbol: assert property (rx_code_strobe[g] && mode_ff && rx_code_group[g] == 10'h17c |=>
      rx_parallel_lane_bits[g][8:0] == 9'h1bc) else $error("control symbol badly decoded");
    chk_rx_d_symbol: assert property (rx_code_strobe[g] && mode_ff && rx_code_group[g] == 10'h155 |=>
      rx_parallel_lane_bits[g] == 10'h0b5) else $error("data symbol badly decoded");
    chk_rx_err_flag: assert property (rx_code_strobe[g] && mode_ff && rx_code_group[g] == 10'h000 |=>
      rx_parallel_lane_bits[g][9]) else $error("invalid group not flagged");
  end
  chk_irq_masked_off: assert property (mask_ff == 12'h000 && $past(mask_ff) == 12'h000 |-> !irq)
    else $error("interrupt raised while fully masked");
  cover property (tx_code_strobe[0] && mode_ff);
  cover property (rx_word_strobe[0] && rx_parallel_lane_bits[0][9] && mode_ff);
  cover property ($rose(irq));
endmodule

bind serdes_parallel_word_codec codec_port_props u_codec_port_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .tx_lane_clock(tx_lane_clock), .tx_parallel_lane_bits(tx_parallel_lane_bits),
  .tx_code_group(tx_code_group), .tx_code_strobe(tx_code_strobe), .rx_code_group(rx_code_group),
  .rx_code_strobe(rx_code_strobe), .rx_parallel_lane_bits(rx_parallel_lane_bits),
  .rx_word_strobe(rx_word_strobe), .irq(irq));

// *** bench/host_word_source.sv ***
// host side of the transmit lanes: lane clocks and parallel words
// assumes pclk at 100 MHz; one word takes an 80 ns lane clock period
`timescale 1ns/1ps
module host_word_source (
  input wire logic pclk,
  output logic [3:0] tx_lane_clock,
  output logic [3:0][9:0] tx_parallel_lane_bits
);
  initial begin
    tx_lane_clock = 4'h0;
    tx_parallel_lane_bits = 40'h0;
  end
  // clock idles low between words; pins pull low once the hold ends
  task automatic send(input int l, input logic [9:0] w);
    tx_parallel_lane_bits[l] <= w;
    repeat (3) @(posedge pclk);
    tx_lane_clock[l] <= 1'b1;
    repeat (4) @(posedge pclk);
    tx_lane_clock[l] <= 1'b0;
    tx_parallel_lane_bits[l] <= 10'h000;
    @(posedge pclk);
  endtask
endmodule

// *** bench/serdes_parallel_word_codec_test.sv ***
// self-checking bench for the four-lane parallel word codec
// assumes the host model and the bound checker are compiled alongside
`timescale 1ns/1ps
`include "codec_defines.svh"
module serdes_parallel_word_codec_test;
  localparam logic [32:0] all_bits = 33'h1ffffffff;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] tx_lane_clock, tx_code_strobe, rx_code_strobe, rx_word_strobe;
  logic [3:0][9:0] tx_parallel_lane_bits, tx_code_group, rx_code_group, rx_parallel_lane_bits;
  int err_total, checks, seed;
  logic [19:0] tx_q[$], rx_q[$];
  logic [65:0] rd_q[$];
  // host words and their code groups from negative disparity on
  logic [9:0] dec [4] = '{10'h1bc, 10'h0b5, 10'h1bc, 10'h000};
  logic [9:0] enc [4] = '{10'h17c, 10'h155, 10'h283, 10'h0b9};
  serdes_parallel_word_codec u_serdes_parallel_word_codec (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_lane_clock(tx_lane_clock), .tx_parallel_lane_bits(tx_parallel_lane_bits),
    .tx_code_group(tx_code_group), .tx_code_strobe(tx_code_strobe), .rx_code_group(rx_code_group),
    .rx_code_strobe(rx_code_strobe), .rx_parallel_lane_bits(rx_parallel_lane_bits),
    .rx_word_strobe(rx_word_strobe), .irq(irq));
  host_word_source u_host_word_source (.pclk(pclk), .tx_lane_clock(tx_lane_clock),
    .tx_parallel_lane_bits(tx_parallel_lane_bits));
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // apb master; one idle edge after each transfer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      err_total++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
    rd_q.push_back({m, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic rx_send(input int l, input logic [9:0] g, input logic [19:0] e);
    rx_q.push_back(e);
    rx_code_group[l] <= g;
    rx_code_strobe[l] <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic rx_idle(input int l);
    rx_code_strobe[l] <= 1'b0;
    rx_code_group[l] <= ~rx_code_group[l];
  endtask
  task automatic drain();
    int n;
    n = 0;
    while ((tx_q.size() + rx_q.size() + rd_q.size()) != 0 && n < 64) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 64) begin
      err_total++;
      wrap_up();
    end
  endtask
  // ==========================================
  // result watcher
  always @(posedge pclk) begin
    logic [65:0] r;
    logic [19:0] t;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      r = rd_q.pop_front();
      check({pslverr, prdata} & r[65:33], r[32:0]);
    end
    for (int l = 0; l < 4; l++) begin
      if (tx_code_strobe[l] === 1'b1) begin
        t = tx_q.pop_front();
        check({23'h0, tx_code_group[l] & t[19:10]}, {23'h0, t[9:0]});
      end
      if (rx_word_strobe[l] === 1'b1) begin
        t = rx_q.pop_front();
        check({23'h0, rx_parallel_lane_bits[l] & t[19:10]}, {23'h0, t[9:0]});
      end
    end
  end
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    logic [9:0] w;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rx_code_group = 40'h0;
    rx_code_strobe = 4'h0;
    err_total = 0;
    checks = 0;
    seed = 32'h297e;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`CTRL_OFFSET, 33'h0, all_bits);
    rd(`MASK_OFFSET, 33'h0, all_bits);
    rd(`STATUS_OFFSET, 33'h0, all_bits);
    for (int l = 0; l < 4; l++) begin
      for (int i = 0; i < 2; i++) begin
        w = 10'($random(seed));
        tx_q.push_back({10'h3ff, w});
        u_host_word_source.send(l, w);
        rx_send(l, ~w, {10'h3ff, ~w});
        rx_idle(l);
      end
    end
    drain();
    rd(`STATUS_OFFSET, 33'h0f0, 33'h0f0);
    rd(`STATUS_OFFSET, 33'h0, all_bits);
    apb(1'b1, `CTRL_OFFSET, 32'h1);
    apb(1'b1, `MASK_OFFSET, 32'h1);
    apb(1'b1, `ERRCNT_OFFSET, 32'h0);
    rd(`CTRL_OFFSET, 33'h1, all_bits);
    // back-to-back receive groups, then an invalid one per lane
    for (int l = 0; l < 4; l++) begin
      for (int i = 0; i < 4; i++) begin
        tx_q.push_back({10'h3ff, enc[i]});
        u_host_word_source.send(l, dec[i]);
      end
      for (int i = 0; i < 4; i++) begin
        rx_send(l, enc[i], {10'h3ff, dec[i]});
      end
      rx_send(l, 10'h347, {10'h3ff, 10'h007});
      rx_send(l, 10'h000, 20'h80200);
      rx_idle(l);
    end
    drain();
    repeat (3) @(posedge pclk);
    check({32'h0, irq}, 33'h1);
    rd(`STATUS_OFFSET, 33'hfff, all_bits);
    repeat (2) @(posedge pclk);
    check({32'h0, irq}, 33'h0);
    rd(`DISP_OFFSET, 33'h0, 33'hff);
    rd(`ERRCNT_OFFSET, 33'h01010101, all_bits);
    apb(1'b1, `ERRCNT_OFFSET, 32'h0);
    rd(`ERRCNT_OFFSET, 33'h0, all_bits);
    rd(12'h014, 33'h100000000, all_bits);
    drain();
    wrap_up();
  end
endmodule
